// ---- rtl/fe_cfg_pkg.sv ----
package fe_cfg_pkg;

    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_MODE     = 8'h10;
    localparam logic [7:0]  OFS_SLOT_CFG = 8'h11;
    localparam logic [7:0]  OFS_SYNC     = 8'h38;
    localparam logic [7:0]  OFS_CLK_CTRL = 8'h4B;
    localparam logic [15:0] RST_MODE     = 16'h0000;
    localparam logic [15:0] RST_SLOT_CFG = 16'h1000;
    localparam logic [15:0] RST_SYNC     = 16'h0000;
    localparam logic [15:0] RST_CLK_CTRL = 16'h2600;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MODE_LSB     = 0;
    localparam int READBACK_BIT = 13;
    localparam int PROTECT_BIT  = 12;
    localparam int B_FMT_LSB    = 6;
    localparam int B_EN_BIT     = 5;
    localparam int A_FMT_LSB    = 2;
    localparam int A_EN_BIT     = 0;
    localparam int BYPASS_BIT   = 8;
    localparam int POWER_BIT    = 7;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_STANDBY = 2'h0;
    localparam logic [1:0] MODE_PROGRAM = 2'h1;
    localparam logic [1:0] MODE_NORMAL  = 2'h2;
    localparam logic [2:0] FMT_NONE     = 3'h0;
    localparam logic [2:0] FMT_SUM16    = 3'h1;
    localparam logic [2:0] FMT_SUM32    = 3'h2;
    localparam logic [2:0] FMT_CH16     = 3'h4;
    localparam logic [2:0] FMT_CH32     = 3'h6;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ  = 100_000_000;
    localparam int OSC_HZ  = 32_000;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic             second;
        logic [3:0][31:0] chan;
    } slot_result_t;

    typedef struct packed {
        logic [1:0] mode;
        logic       readback_sum_or_average;
        logic       queue_overflow_protect;
        logic [2:0] second_slot_queue_format;
        logic       second_slot_enable;
        logic [2:0] first_slot_queue_format;
        logic       first_slot_enable;
        logic       sample_oscillator_bypass;
        logic       sample_clock_power_up;
    } cfg_t;

endpackage : fe_cfg_pkg

// ---- rtl/queue_store.sv ----
`timescale 1ns/10ps
module queue_store #(
    parameter int W     = 16,
    parameter int DEPTH = 64,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Mode
    input  wire logic         protect,
    // Fill side
    input  wire logic         push,
    input  wire logic [W-1:0] push_data,
    output logic              drop,
    // Drain side
    input  wire logic         pop,
    output logic [W-1:0]      pop_data,
    output logic              pop_valid,
    output logic [AW:0]       level,
    output logic              full
);

    logic [DEPTH-1:0][W-1:0] mem_r;
    logic [AW-1:0]           wptr_r, wptr_nxt, rptr_r, rptr_nxt;
    logic [AW:0]             cnt_r, cnt_nxt;
    logic [W-1:0]            data_r, data_nxt;
    logic                    vld_r, vld_nxt, drop_r, drop_nxt, full_r, full_nxt;
    logic                    wen, ren;

    always_comb
    begin
        ren      = pop && (cnt_r != '0);
        wen      = push && !(full_r && protect);
        wptr_nxt = wen ? wptr_r + 1'b1 : wptr_r;
        rptr_nxt = rptr_r;
        cnt_nxt  = cnt_r;
        if (ren || (wen && full_r))
        begin
            // Overwrite mode drops the oldest word
            rptr_nxt = rptr_r + 1'b1;
        end
        if (wen && !ren && !full_r)
        begin
            cnt_nxt = cnt_r + 1'b1;
        end
        else if (ren && !wen)
        begin
            cnt_nxt = cnt_r - 1'b1;
        end
        full_nxt = (cnt_nxt == (AW+1)'(DEPTH));
        data_nxt = ren ? mem_r[rptr_r] : data_r;
        vld_nxt  = ren;
        drop_nxt = push && !wen;
    end

    always_ff @(posedge clk)
    begin
        if (wen)
        begin
            mem_r[wptr_r] <= push_data;
        end
        if (srst)
        begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r  <= '0;
            data_r <= '0;
            vld_r  <= 1'b0;
            drop_r <= 1'b0;
            full_r <= 1'b0;
        end
        else
        begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            cnt_r  <= cnt_nxt;
            data_r <= data_nxt;
            vld_r  <= vld_nxt;
            drop_r <= drop_nxt;
            full_r <= full_nxt;
        end
    end

    assign pop_data  = data_r;
    assign pop_valid = vld_r;
    assign level     = cnt_r;
    assign full      = full_r;
    assign drop      = drop_r;

    property p_protect_keeps;
        @(posedge clk) disable iff (srst)
        protect && full_r && push && !pop |=> full_r && rptr_r == $past(rptr_r) && drop_r;
    endproperty
    a_protect_keeps: assert property (p_protect_keeps) else $error("full queue accepted");

    property p_wrap_overwrites;
        @(posedge clk) disable iff (srst)
        !protect && full_r && push && !pop |=> full_r && rptr_r == $past(rptr_r) + 1'b1;
    endproperty
    a_wrap_overwrites: assert property (p_wrap_overwrites) else $error("no overwrite");

    c_overwrite: cover property (@(posedge clk) !protect && full_r && push);

endmodule : queue_store

// ---- rtl/front_end_config.sv ----
`timescale 1ns/10ps
// How it works
// - Mode field: standby, program, normal
// - Bit 13 picks sum or average in the 32-bit formats
// - Bit 12 blocks or overwrites when full
// - Bits 8..6 give second-slot queue format
// - Bits 4..2 give first-slot queue format
// - Second slot stored only if factors match or the first-slot format is none
// - Bit 5 enables second slot
// - Bit 0 enables first slot
// - Bit 8 selects pin clock over oscillator
// - Bit 7 powers the sample clock
module front_end_config #(
    parameter int QUEUE_DEPTH = 64,
    parameter int OSC_DIV     = fe_cfg_pkg::OSC_DIV
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     srst,
    // Register access from the serial port
    input  wire logic [7:0]               reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic [15:0]              reg_wdata,
    input  wire logic                     reg_rd,
    output logic [15:0]                   reg_rdata,
    output logic                          reg_rvalid,
    // External sample clock and averaging factors
    input  wire logic                     general_pin_one,
    input  wire logic [2:0]               first_slot_avg_factor,
    input  wire logic [2:0]               second_slot_avg_factor,
    // Slot results
    input  wire logic                     result_valid,
    input  wire fe_cfg_pkg::slot_result_t result,
    // Slot control and status
    output logic                          first_slot_start,
    output logic                          second_slot_start,
    output logic                          sample_clock_enable,
    output logic                          mode_standby,
    output logic                          mode_program,
    output logic                          mode_normal,
    // Queue drain
    input  wire logic                     queue_pop,
    output logic [15:0]                   queue_data,
    output logic                          queue_data_valid,
    output logic [$clog2(QUEUE_DEPTH):0]  queue_level,
    output logic                          queue_full,
    output logic                          queue_drop
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0]      mode_r, mode_nxt, slot_r, slot_nxt, sync_r, sync_nxt;
    logic [15:0]      clk_r, clk_nxt, rdata_r, rdata_nxt;
    logic             rvalid_r, rvalid_nxt;
    logic [2:0]       mflag_r, mflag_nxt;
    fe_cfg_pkg::cfg_t cfg;

    always_comb
    begin
        mode_nxt   = mode_r;
        slot_nxt   = slot_r;
        sync_nxt   = sync_r;
        clk_nxt    = clk_r;
        rdata_nxt  = 16'h0000;
        rvalid_nxt = reg_rd;
        if (reg_wr)
        begin
            case (reg_addr)
                fe_cfg_pkg::OFS_MODE:     mode_nxt = reg_wdata;
                fe_cfg_pkg::OFS_SLOT_CFG: slot_nxt = reg_wdata;
                fe_cfg_pkg::OFS_SYNC:     sync_nxt = reg_wdata;
                fe_cfg_pkg::OFS_CLK_CTRL: clk_nxt  = reg_wdata;
                default:                  mode_nxt = mode_r;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                fe_cfg_pkg::OFS_MODE:     rdata_nxt = mode_r;
                fe_cfg_pkg::OFS_SLOT_CFG: rdata_nxt = slot_r;
                fe_cfg_pkg::OFS_SYNC:     rdata_nxt = sync_r;
                fe_cfg_pkg::OFS_CLK_CTRL: rdata_nxt = clk_r;
                default:                  rdata_nxt = 16'h0000;
            endcase
        end
        // Mode code 3 is undefined and leaves all flags low
        mflag_nxt = {mode_nxt[fe_cfg_pkg::MODE_LSB +: 2] == fe_cfg_pkg::MODE_NORMAL,
                     mode_nxt[fe_cfg_pkg::MODE_LSB +: 2] == fe_cfg_pkg::MODE_PROGRAM,
                     mode_nxt[fe_cfg_pkg::MODE_LSB +: 2] == fe_cfg_pkg::MODE_STANDBY};
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mode_r   <= fe_cfg_pkg::RST_MODE;
            slot_r   <= fe_cfg_pkg::RST_SLOT_CFG;
            sync_r   <= fe_cfg_pkg::RST_SYNC;
            clk_r    <= fe_cfg_pkg::RST_CLK_CTRL;
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
            mflag_r  <= 3'h1;
        end
        else
        begin
            mode_r   <= mode_nxt;
            slot_r   <= slot_nxt;
            sync_r   <= sync_nxt;
            clk_r    <= clk_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            mflag_r  <= mflag_nxt;
        end
    end

    always_comb
    begin
        cfg.mode                     = mode_r[fe_cfg_pkg::MODE_LSB +: 2];
        cfg.readback_sum_or_average  = slot_r[fe_cfg_pkg::READBACK_BIT];
        cfg.queue_overflow_protect   = slot_r[fe_cfg_pkg::PROTECT_BIT];
        cfg.second_slot_queue_format = slot_r[fe_cfg_pkg::B_FMT_LSB +: 3];
        cfg.second_slot_enable       = slot_r[fe_cfg_pkg::B_EN_BIT];
        cfg.first_slot_queue_format  = slot_r[fe_cfg_pkg::A_FMT_LSB +: 3];
        cfg.first_slot_enable        = slot_r[fe_cfg_pkg::A_EN_BIT];
        cfg.sample_oscillator_bypass = clk_r[fe_cfg_pkg::BYPASS_BIT];
        cfg.sample_clock_power_up    = clk_r[fe_cfg_pkg::POWER_BIT];
    end

    // ------------------------------------------------------------
    // Sample clock and slot starts
    // ------------------------------------------------------------
    localparam logic [11:0] DIV_LAST = 12'(OSC_DIV - 1);

    logic [11:0] div_r, div_nxt;
    logic        pin_prev_r, a_start_r, a_start_nxt, b_start_r, b_start_nxt;
    logic        running, tick;

    always_comb
    begin
        running = cfg.sample_clock_power_up
                  && (cfg.mode == fe_cfg_pkg::MODE_NORMAL);
        div_nxt = (!running || div_r == DIV_LAST) ? 12'h000 : div_r + 12'h001;
        if (cfg.sample_oscillator_bypass)
        begin
            tick = running && general_pin_one && !pin_prev_r;
        end
        else
        begin
            tick = running && (div_r == DIV_LAST);
        end
        a_start_nxt = tick && cfg.first_slot_enable;
        // Second slot follows the first by one cycle when both run
        b_start_nxt = running && cfg.second_slot_enable
                      && (cfg.first_slot_enable ? a_start_r : tick);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            div_r      <= 12'h000;
            pin_prev_r <= 1'b0;
            a_start_r  <= 1'b0;
            b_start_r  <= 1'b0;
        end
        else
        begin
            div_r      <= div_nxt;
            pin_prev_r <= general_pin_one;
            a_start_r  <= a_start_nxt;
            b_start_r  <= b_start_nxt;
        end
    end

    // ------------------------------------------------------------
    // Result formatting
    // ------------------------------------------------------------
    logic [7:0][15:0] fmt_words;
    logic [3:0]       fmt_count;
    logic [2:0]       fmt, nshift;
    logic [31:0]      sum4, scaled;
    logic             accept;

    always_comb
    begin
        fmt       = result.second ? cfg.second_slot_queue_format
                                  : cfg.first_slot_queue_format;
        nshift    = result.second ? second_slot_avg_factor : first_slot_avg_factor;
        sum4      = result.chan[0] + result.chan[1] + result.chan[2] + result.chan[3];
        scaled    = cfg.readback_sum_or_average ? sum4 >> nshift : sum4;
        fmt_words = '0;
        fmt_count = 4'h0;
        case (fmt)
            fe_cfg_pkg::FMT_SUM16:
            begin
                fmt_words[0] = sum4[15:0];
                fmt_count    = 4'h1;
            end
            fe_cfg_pkg::FMT_SUM32:
            begin
                fmt_words[1:0] = scaled;
                fmt_count      = 4'h2;
            end
            fe_cfg_pkg::FMT_CH16:
            begin
                for (int i = 0; i < 4; i++)
                begin
                    fmt_words[i] = result.chan[i][15:0];
                end
                fmt_count = 4'h4;
            end
            fe_cfg_pkg::FMT_CH32:
            begin
                for (int i = 0; i < 4; i++)
                begin
                    fmt_words[2*i +: 2] = cfg.readback_sum_or_average
                                          ? result.chan[i] >> nshift : result.chan[i];
                end
                fmt_count = 4'h8;
            end
            default: fmt_count = 4'h0;
        endcase
        accept = result_valid && running
                 && (result.second ? cfg.second_slot_enable : cfg.first_slot_enable)
                 && (fmt_count != 4'h0)
                 && (!result.second
                     || first_slot_avg_factor == second_slot_avg_factor
                     || cfg.first_slot_queue_format == fe_cfg_pkg::FMT_NONE);
    end

    // ------------------------------------------------------------
    // Word pusher
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_PUSH = 2'b10
    } push_state_t;

    push_state_t      state_r, state_nxt;
    logic [7:0][15:0] words_r, words_nxt;
    logic [3:0]       n_r, n_nxt, idx_r, idx_nxt;
    logic             push;

    always_comb
    begin
        state_nxt = state_r;
        words_nxt = words_r;
        n_nxt     = n_r;
        idx_nxt   = idx_r;
        push      = 1'b0;
        case (state_r)
            S_IDLE:
            begin
                // Results arriving mid-push are dropped
                if (accept)
                begin
                    words_nxt = fmt_words;
                    n_nxt     = fmt_count;
                    idx_nxt   = 4'h0;
                    state_nxt = S_PUSH;
                end
            end
            S_PUSH:
            begin
                if (!running)
                begin
                    state_nxt = S_IDLE;
                end
                else
                begin
                    push    = 1'b1;
                    idx_nxt = idx_r + 4'h1;
                    if (idx_r == n_r - 4'h1)
                    begin
                        state_nxt = S_IDLE;
                    end
                end
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r <= S_IDLE;
            words_r <= '0;
            n_r     <= 4'h0;
            idx_r   <= 4'h0;
        end
        else
        begin
            state_r <= state_nxt;
            words_r <= words_nxt;
            n_r     <= n_nxt;
            idx_r   <= idx_nxt;
        end
    end

    queue_store #(
        .W     (16),
        .DEPTH (QUEUE_DEPTH)
    ) u_queue (
        .clk       (clk),
        .srst      (srst),
        .protect   (cfg.queue_overflow_protect),
        .push      (push),
        .push_data (words_r[idx_r[2:0]]),
        .drop      (queue_drop),
        .pop       (queue_pop),
        .pop_data  (queue_data),
        .pop_valid (queue_data_valid),
        .level     (queue_level),
        .full      (queue_full)
    );

    assign reg_rdata           = rdata_r;
    assign reg_rvalid          = rvalid_r;
    assign first_slot_start    = a_start_r;
    assign second_slot_start   = b_start_r;
    assign sample_clock_enable = clk_r[fe_cfg_pkg::POWER_BIT];
    assign mode_standby        = mflag_r[0];
    assign mode_program        = mflag_r[1];
    assign mode_normal         = mflag_r[2];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_mode_gate;
        @(posedge clk) disable iff (srst)
        !mode_normal |=> !first_slot_start && !second_slot_start;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("start outside normal");

    property p_avg32;
        @(posedge clk) disable iff (srst)
        accept && fmt == fe_cfg_pkg::FMT_SUM32 |=> {words_r[1], words_r[0]} ==
            ($past(cfg.readback_sum_or_average) ? $past(sum4) >> $past(nshift) : $past(sum4));
    endproperty
    a_avg32: assert property (p_avg32) else $error("bad sum or average");

    property p_ch32_count;
        @(posedge clk) disable iff (srst)
        accept && result.second && fmt == fe_cfg_pkg::FMT_CH32 |=> n_r == 4'h8 ##[1:8] push;
    endproperty
    a_ch32_count: assert property (p_ch32_count) else $error("wrong word count");

    property p_reserved;
        @(posedge clk) disable iff (srst)
        state_r == S_IDLE && result_valid && !result.second && fmt == 3'h3 |=> state_r == S_IDLE;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code stored");

    property p_pair;
        @(posedge clk) disable iff (srst)
        state_r == S_IDLE && result_valid && result.second
            && first_slot_avg_factor != second_slot_avg_factor
            && cfg.first_slot_queue_format != fe_cfg_pkg::FMT_NONE |=> state_r == S_IDLE;
    endproperty
    a_pair: assert property (p_pair) else $error("unmatched second slot stored");

    property p_b_off;
        @(posedge clk) disable iff (srst)
        !cfg.second_slot_enable |=> !second_slot_start;
    endproperty
    a_b_off: assert property (p_b_off) else $error("second slot ran disabled");

    property p_a_follow;
        @(posedge clk) disable iff (srst)
        $rose(first_slot_start) && cfg.second_slot_enable && running |=> second_slot_start;
    endproperty
    a_a_follow: assert property (p_a_follow) else $error("second slot missed");

    property p_pin_clock;
        @(posedge clk) disable iff (srst)
        cfg.sample_oscillator_bypass && !general_pin_one |=> !first_slot_start;
    endproperty
    a_pin_clock: assert property (p_pin_clock) else $error("start without pin edge");

    property p_power;
        @(posedge clk) disable iff (srst)
        !sample_clock_enable |-> ##1 (!first_slot_start && !second_slot_start);
    endproperty
    a_power: assert property (p_power) else $error("start while unpowered");

    property p_no_push;
        @(posedge clk) disable iff (srst)
        !running |-> !push;
    endproperty
    a_no_push: assert property (p_no_push) else $error("push while stopped");

    c_both_slots: cover property (@(posedge clk) first_slot_start ##1 second_slot_start);
    c_ch32:       cover property (@(posedge clk) accept && fmt == fe_cfg_pkg::FMT_CH32);
    c_pin_tick:   cover property (@(posedge clk) tick && cfg.sample_oscillator_bypass);

endmodule : front_end_config

// ---- tb/front_end_config_tb.sv ----
`timescale 1ns/10ps
module front_end_config_tb;
    logic                     clk = 1'b0;
    logic                     srst = 1'b1;
    logic [7:0]               addr = 8'h00;
    logic                     wr = 1'b0;
    logic                     rd = 1'b0;
    logic [15:0]              wd = 16'h0000;
    logic                     pin = 1'b0;
    logic [2:0]               fa = 3'h2;
    logic [2:0]               fb = 3'h0;
    logic                     rv = 1'b0;
    fe_cfg_pkg::slot_result_t res = '0;
    logic                     pop = 1'b0;
    logic [15:0]              rdata, qd;
    logic                     rvalid, st_a, st_b, sclk, m0, m1, m2, qv, qf, drop;
    logic [2:0]               lvl;
    int                       fails = 0;
    int                       n_tests = 0;
    int                       c, cb;
    int                       nd = 0;

    always #5 clk = ~clk;

    // Drop is high one cycle per dropped word, so each cycle is tallied as it passes
    always @(negedge clk)
        if (drop === 1'b1)
            nd++;

    front_end_config #(.QUEUE_DEPTH(4), .OSC_DIV(4)) dut (
        .clk(clk), .srst(srst), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd),
        .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid), .general_pin_one(pin),
        .first_slot_avg_factor(fa), .second_slot_avg_factor(fb), .result_valid(rv),
        .result(res), .first_slot_start(st_a), .second_slot_start(st_b),
        .sample_clock_enable(sclk), .mode_standby(m0), .mode_program(m1),
        .mode_normal(m2), .queue_pop(pop), .queue_data(qd), .queue_data_valid(qv),
        .queue_level(lvl), .queue_full(qf), .queue_drop(drop));

    // ----------------------------------------
    // Shared bus and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wreg

    task automatic rreg(input logic [7:0] a, input logic [15:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk((rvalid === 1'b1) ? rdata : 16'hFFFF, e);
    endtask : rreg

    // Same value on all channels keeps the expected sum simple
    task automatic push(input logic s, input logic [31:0] v);
        @(negedge clk);
        res = {s, v, v, v, v};
        rv = 1'b1;
        @(negedge clk);
        rv = 1'b0;
        repeat (10) @(negedge clk);
    endtask : push

    task automatic popchk(input logic [15:0] e);
        @(negedge clk);
        pop = 1'b1;
        @(negedge clk);
        pop = 1'b0;
        chk((qv === 1'b1) ? qd : 16'hFFFF, e);
    endtask : popchk

    task automatic starts(input int n);
        c = 0;
        cb = 0;
        repeat (n)
        begin
            @(negedge clk);
            c += int'(st_a === 1'b1);
            cb += int'(st_b === 1'b1);
        end
    endtask : starts

    task automatic results;
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rreg(8'h11, 16'h1000);
        rreg(8'h38, 16'h0000);
        rreg(8'h4B, 16'h2600);
        rreg(8'h20, 16'h0000);
        wreg(8'h38, 16'h4000);
        rreg(8'h38, 16'h4000);
        for (int i = 0; i < 3; i++)
        begin
            wreg(8'h10, 16'(i));
            @(negedge clk);
            chk({13'h0, m2, m1, m0}, 16'h1 << i);
        end
    endtask : t_regs

    task automatic t_clock;
        wreg(8'h11, 16'h1021);
        wreg(8'h4B, 16'h2680);
        starts(3);
        starts(8);
        chk(16'(c), 16'h0002);
        chk(16'(cb), 16'h0002);
        wreg(8'h4B, 16'h2780);
        starts(12);
        chk(16'(c), 16'h0000);
        pin = 1'b1;
        starts(3);
        chk(16'(c), 16'h0001);
        pin = 1'b0;
        wreg(8'h4B, 16'h2600);
        starts(12);
        chk(16'(c + cb), 16'h0000);
        chk({15'h0, sclk}, 16'h0000);
    endtask : t_clock

    task automatic t_queue;
        wreg(8'h4B, 16'h2680);
        wreg(8'h11, 16'h3009);
        push(1'b0, 32'h0001_0003);
        popchk(16'h0003);
        popchk(16'h0001);
        wreg(8'h11, 16'h1009);
        push(1'b0, 32'h0001_0003);
        popchk(16'h000C);
        popchk(16'h0004);
        wreg(8'h11, 16'h1011);
        push(1'b0, 32'h5);
        chk({15'h0, qf}, 16'h0001);
        push(1'b0, 32'h7);
        for (int i = 0; i < 4; i++)
            popchk(16'h0005);
        chk(16'(nd), 16'h0004);
        wreg(8'h11, 16'h0011);
        push(1'b0, 32'h5);
        push(1'b0, 32'h7);
        for (int i = 0; i < 4; i++)
            popchk(16'h0007);
        chk(16'(nd), 16'h0004);
        wreg(8'h11, 16'h1125);
        fa = 3'h1;
        push(1'b1, 32'h9);
        chk(16'(lvl), 16'h0000);
        fb = 3'h1;
        push(1'b1, 32'h9);
        chk(16'(lvl), 16'h0004);
        for (int i = 0; i < 4; i++)
            popchk(16'h0009);
        push(1'b0, 32'h9);
        popchk(16'h0024);
        // First slot silent, so unequal factors still let the second slot in
        fa = 3'h2;
        wreg(8'h11, 16'h21A0);
        push(1'b1, 32'h0002_0004);
        for (int i = 0; i < 2; i++)
        begin
            popchk(16'h0002);
            popchk(16'h0001);
        end
        wreg(8'h11, 16'h100D);
        push(1'b0, 32'h5);
        chk(16'(lvl), 16'h0000);
    endtask : t_queue

    initial
    begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        t_regs();
        t_clock();
        t_queue();
        results();
    end

    initial
    begin
        #50000;
        fails++;
        results();
    end
endmodule : front_end_config_tb
